// [rtl/isc_pkg.sv]
// Package: offsets, field positions and reset values of the status collector
package isc_pkg;
    localparam logic [11:0] ISC_PRIMARY_STATUS_OFS = 12'h410;
    localparam logic [11:0] ISC_ERROR_STATUS_OFS   = 12'h414;
    localparam logic [11:0] ISC_ENABLE_OFS         = 12'h418;
    localparam logic [11:0] ISC_ERROR_ENABLE_OFS   = 12'h41c;
    localparam logic [11:0] ISC_MAILBOX_BASE_OFS   = 12'h440;
    localparam logic [31:0] ISC_STATUS_RESET       = 32'h00000000;
    localparam logic [31:0] ISC_ENABLE_RESET       = 32'h00000000;

    // Primary register field positions
    localparam int ISC_P_SUMMARY   = 31;
    localparam int ISC_P_HOST_Q    = 29;
    localparam int ISC_P_LOCAL_Q   = 28;
    localparam int ISC_P_DMA_LO    = 24;
    localparam int ISC_P_SECOND_HW = 23;
    localparam int ISC_P_FIRST_HW  = 22;
    localparam int ISC_P_GEN_LO    = 16;
    localparam int ISC_P_DB_LO     = 8;
    localparam int ISC_P_MBOX_LO   = 0;

    // Primary bits software may clear
    localparam logic [31:0] ISC_PRIMARY_W1C = 32'h1fffffff;
    // Error register: writable bits (bit 31 summary, bit 0 of each byte reserved)
    localparam logic [31:0] ISC_ERROR_W1C   = 32'h0efefefe;
    // Bits tied to the second PCI interface
    localparam logic [31:0] ISC_P_SECOND_MASK = 32'h00800000;
    localparam logic [31:0] ISC_E_SECOND_MASK = 32'h0444fe88;
endpackage

// [rtl/isc_sync_if.sv]
// Interface: raw event inputs handed to the synchroniser
interface isc_sync_if;
    logic [7:0] raw;
    logic [7:0] synced;
    modport src  (output raw, input synced);
    modport sync (input raw, output synced);
endinterface

// [rtl/isc_sync.sv]
// Two-flop synchroniser for pin-level interrupt inputs
module isc_sync
    import isc_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst_b,    // Async reset, active low
    isc_sync_if.sync  port_if  // Raw in, synchronised out
);
    logic [7:0] stage1_reg;
    logic [7:0] stage2_reg;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_reg <= 8'h00;
            stage2_reg <= 8'h00;
        end else begin
            stage1_reg <= port_if.raw;
            stage2_reg <= stage1_reg;
        end
    end

    assign port_if.synced = stage2_reg;
endmodule

// [rtl/isc_top.sv]
// Top: interrupt status collector with two status registers and an enable pair
//
// Function
// - Primary status register, bit per active source.
// - Primary summary bit ORs error register bits.
// - Error summary bit ORs primary register bits.
// - Host queue bit mirrors outbound list status.
// - Local queue bit sets on inbound entries.
// - Four DMA bits set per channel interrupt.
// - PCI line bits set on INTA level.
// - Six general line bits from active-low pins.
// - Doorbell bits set by enable register writes.
// - Mailbox bits set on mailbox writes.
// - Error register, all bits zero on reset.
// - Retry-limit bits per cpu-bus path.
// - Transfer error acknowledge bits per path.
// - One cpu-bus address parity bit.
// - Data parity bits per cpu-bus path.
// - PCI error bits; software checks interface status.
// - Address parity bit per PCI interface.
// - PCI master retry bits per path.
// - Single-PCI variant never sets second-PCI bits.
// - Interrupt output for enabled active bits; host queue bit fires while its enable bit is clear.
// - Doorbell stays set until software clears.
//
// Added by the designer: strobed register access.
module isc_top
    import isc_pkg::*;
#(
    parameter bit SINGLE_PCI = 1'b0 // Single-PCI variant
)(
    input  wire logic        core_clk,                 // Clock, 50 MHz
    input  wire logic        rst_b,                    // Async reset, active low
    input  wire logic [11:0] reg_addr,                 // Register byte address
    input  wire logic [31:0] reg_wdata,                // Write data
    input  wire logic        reg_wr,                   // Write strobe
    input  wire logic        reg_rd,                   // Read strobe
    output logic      [31:0] reg_rdata,                // Read data, cycle after strobe
    input  wire logic        host_queue_pending,       // Outbound list nonempty
    input  wire logic        local_queue_pending,      // Inbound list nonempty
    input  wire logic [3:0]  dma_channel_event,        // DMA channel interrupt pulses
    input  wire logic        first_pci_inta_b,         // First PCI INTA pin, active low
    input  wire logic        second_pci_inta_b,        // Second PCI INTA pin, active low
    input  wire logic [5:0]  general_line_b,           // General interrupt pins, active low
    input  wire logic [2:0]  cpu_retry_limit,          // Retry limit: first, second, dma
    input  wire logic [2:0]  cpu_bus_transfer_error_ack, // Transfer error: first, second, dma
    input  wire logic        cpu_bus_addr_parity_err,  // Cpu-bus address parity error
    input  wire logic [2:0]  cpu_data_parity_err,      // Data parity: first, second, dma
    input  wire logic [2:0]  second_pci_err,           // Second PCI error: first, cpu, same
    input  wire logic        second_pci_addr_parity_err, // Second PCI address parity
    input  wire logic [2:0]  second_pci_retry,         // Second PCI retry: first, cpu, same
    input  wire logic [2:0]  first_pci_err,            // First PCI error: second, cpu, same
    input  wire logic        first_pci_addr_parity_err, // First PCI address parity
    input  wire logic [2:0]  first_pci_retry,          // First PCI retry: second, cpu, same
    output logic             irq_out                   // Enabled status active
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    isc_sync_if pins_if ();
    assign pins_if.raw = {~second_pci_inta_b, ~first_pci_inta_b, ~general_line_b};

    isc_sync u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .port_if  (pins_if.sync)
    );

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic [31:0] primary_reg;
    logic [31:0] primary_next;
    logic [31:0] error_reg;
    logic [31:0] error_next;
    logic [31:0] enable_reg;
    logic [31:0] enable_next;
    logic [31:0] err_enable_reg;
    logic [31:0] err_enable_next;
    logic [31:0] reg_rdata_next;
    logic        irq_next;

    wire wr_primary = reg_wr && (reg_addr == ISC_PRIMARY_STATUS_OFS);
    wire wr_error   = reg_wr && (reg_addr == ISC_ERROR_STATUS_OFS);
    wire wr_enable  = reg_wr && (reg_addr == ISC_ENABLE_OFS);
    wire wr_err_en  = reg_wr && (reg_addr == ISC_ERROR_ENABLE_OFS);
    wire [7:0] mbox_hit = mailbox_decode(reg_addr, reg_wr);

    // Mailbox writes land on eight consecutive words from the mailbox base
    function automatic logic [7:0] mailbox_decode(input logic [11:0] addr, input logic wr);
        logic [7:0] hit;
        hit = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (wr && addr == ISC_MAILBOX_BASE_OFS + 12'(4 * i)) begin
                hit[i] = 1'b1;
            end
        end
        return hit;
    endfunction

    // W1C: set wins over clear; zero leaves bit alone
    function automatic logic [31:0] w1c(input logic [31:0] cur, input logic [31:0] set,
                                        input logic [31:0] clr, input logic [31:0] msk);
        return (cur & ~(clr & msk)) | set;
    endfunction

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    wire [7:0] lines = pins_if.synced;

    // Doorbell bits are write-one-to-set through the enable register
    wire [7:0] doorbell_ring = wr_enable ? reg_wdata[15:8] : 8'h00;

    logic [31:0] primary_set;
    always_comb begin
        primary_set = 32'h00000000;
        primary_set[ISC_P_LOCAL_Q] = local_queue_pending;
        primary_set[ISC_P_DMA_LO +: 4] = dma_channel_event;
        primary_set[ISC_P_FIRST_HW] = lines[6];
        primary_set[ISC_P_SECOND_HW] = lines[7];
        primary_set[ISC_P_GEN_LO +: 6] = lines[5:0];
        primary_set[ISC_P_DB_LO +: 8] = doorbell_ring;
        primary_set[ISC_P_MBOX_LO +: 8] = mbox_hit;
        if (SINGLE_PCI) begin
            primary_set = primary_set & ~ISC_P_SECOND_MASK;
        end
    end

    // Error layout per byte: bit0 reserved, bits 7..1 as listed
    wire [31:0] error_set_raw = {
        1'b0, 3'b000, cpu_retry_limit, 1'b0,
        cpu_bus_transfer_error_ack, cpu_bus_addr_parity_err,
        cpu_data_parity_err, 1'b0,
        second_pci_err, second_pci_addr_parity_err, second_pci_retry, 1'b0,
        first_pci_err, first_pci_addr_parity_err, first_pci_retry, 1'b0
    };
    wire [31:0] error_set = SINGLE_PCI ? (error_set_raw & ~ISC_E_SECOND_MASK) : error_set_raw;

    // ------------------------------------------------------------
    // Status registers
    // ------------------------------------------------------------
    wire [31:0] primary_clr = wr_primary ? reg_wdata : 32'h00000000;
    wire [31:0] error_clr   = wr_error ? reg_wdata : 32'h00000000;

    // Stored bits exclude summaries and mirrored host queue bit
    wire [31:0] primary_store = w1c(primary_reg, primary_set, primary_clr, ISC_PRIMARY_W1C)
                                & ISC_PRIMARY_W1C;
    wire [31:0] error_store = w1c(error_reg, error_set, error_clr, ISC_ERROR_W1C)
                              & ISC_ERROR_W1C;

    logic host_mirror_reg;
    logic host_mirror_next;
    assign host_mirror_next = host_queue_pending;

    // Summary bits computed from the other register's stored bits; the error summary also ORs in the host queue mirror
    wire primary_any = (|(primary_reg & ISC_PRIMARY_W1C)) | host_mirror_reg;
    wire error_any   = |(error_reg & ISC_ERROR_W1C);

    always_comb begin
        primary_next = primary_store;
        error_next   = error_store;
    end

    // ------------------------------------------------------------
    // Enable registers
    // ------------------------------------------------------------
    // Doorbell positions are write-one-to-set only and read zero
    localparam logic [31:0] ISC_ENABLE_RW = 32'h3fff00ff;
    assign enable_next     = wr_enable ? (reg_wdata & ISC_ENABLE_RW) : enable_reg;
    assign err_enable_next = wr_err_en ? (reg_wdata & ISC_ERROR_W1C) : err_enable_reg;

    wire [31:0] primary_view = primary_reg
                             | (32'(host_mirror_reg) << ISC_P_HOST_Q)
                             | (32'(error_any) << ISC_P_SUMMARY);
    wire [31:0] error_view = error_reg | (32'(primary_any) << 31);

    // Host queue bit uses a mask with inverted sense
    wire host_irq = host_mirror_reg & ~enable_reg[ISC_P_HOST_Q];
    assign irq_next = host_irq
                    | (|(primary_reg & enable_reg & ~(32'h1 << ISC_P_HOST_Q)))
                    | (|(error_reg & err_enable_reg));

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        reg_rdata_next = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                ISC_PRIMARY_STATUS_OFS: reg_rdata_next = primary_view;
                ISC_ERROR_STATUS_OFS:   reg_rdata_next = error_view;
                ISC_ENABLE_OFS:         reg_rdata_next = enable_reg;
                ISC_ERROR_ENABLE_OFS:   reg_rdata_next = err_enable_reg;
                default:                reg_rdata_next = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Flip-flops
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            primary_reg     <= ISC_STATUS_RESET;
            error_reg       <= ISC_STATUS_RESET;
            enable_reg      <= ISC_ENABLE_RESET;
            err_enable_reg  <= ISC_ENABLE_RESET;
            host_mirror_reg <= 1'b0;
            reg_rdata       <= 32'h00000000;
            irq_out         <= 1'b0;
        end else begin
            primary_reg     <= primary_next;
            error_reg       <= error_next;
            enable_reg      <= enable_next;
            err_enable_reg  <= err_enable_next;
            host_mirror_reg <= host_mirror_next;
            reg_rdata       <= reg_rdata_next;
            irq_out         <= irq_next;
        end
    end
endmodule

// [testbench/isc_pin_model.sv]
// Pin-side model: drives the active-low interrupt pins from level requests
module isc_pin_model (
    input  wire logic       core_clk,          // Clock
    input  wire logic [7:0] pin_req,           // Requests: second, first, general
    output logic            first_pci_inta_b,  // First INTA, active low
    output logic            second_pci_inta_b, // Second INTA, active low
    output logic [5:0]      general_line_b     // General pins, active low
);
    timeunit 1ns;
    timeprecision 1ns;
    // Lines follow the requests one clock later, active low
    always @(posedge core_clk)
        {second_pci_inta_b, first_pci_inta_b, general_line_b} <= ~pin_req;
endmodule

// [testbench/isc_top_asserts.sv]
// Checker: read-back and event capture properties of the status collector
module isc_top_asserts
    import isc_pkg::*;
(
    input wire logic        core_clk,               // Clock
    input wire logic        rst_b,                  // Reset, active low
    input wire logic [11:0] reg_addr,               // Address
    input wire logic [31:0] reg_wdata,              // Write data
    input wire logic        reg_wr,                 // Write strobe
    input wire logic        reg_rd,                 // Read strobe
    input wire logic [31:0] reg_rdata,              // Read data
    input wire logic        host_queue_pending,     // Outbound level
    input wire logic [3:0]  dma_channel_event,      // DMA events
    input wire logic [5:0]  general_line_b,         // General pins
    input wire logic        cpu_bus_addr_parity_err // Address parity
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire rd_p = reg_rd && reg_addr == ISC_PRIMARY_STATUS_OFS;
    wire rd_e = reg_rd && reg_addr == ISC_ERROR_STATUS_OFS;
    wire rd_x = reg_rd && !(reg_addr inside {ISC_PRIMARY_STATUS_OFS, ISC_ERROR_STATUS_OFS,
                                             ISC_ENABLE_OFS, ISC_ERROR_ENABLE_OFS});
    // --------
    // Properties
    // --------
    unmapped_read_a: assert property (rd_x |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    primary_rsvd_a: assert property (rd_p |=> !reg_rdata[30])
        else $error("primary reserved bit set");
    error_rsvd_a: assert property (rd_e |=> (reg_rdata & 32'h71010101) == 32'h0)
        else $error("error reserved bits set");
    dma_capture_a: assert property (dma_channel_event[0] ##1 !(reg_wr && reg_wdata[24]) [*3] ##1 rd_p
        |=> reg_rdata[ISC_P_DMA_LO]) else $error("dma event lost");
    parity_capture_a: assert property (cpu_bus_addr_parity_err ##1 !reg_wr ##1 rd_e |=> reg_rdata[20])
        else $error("address parity event lost");
    error_summary_a: assert property (cpu_bus_addr_parity_err ##1 !reg_wr [*3] ##1 rd_p
        |=> reg_rdata[ISC_P_SUMMARY]) else $error("primary summary low");
    host_mirror_a: assert property (host_queue_pending [*3] ##0 rd_p |=> reg_rdata[ISC_P_HOST_Q])
        else $error("host queue bit low");
    pin_capture_a: assert property (!general_line_b[0] [*3] ##1 rd_p |=> reg_rdata[ISC_P_GEN_LO])
        else $error("general line event lost");
    mailbox_capture_a: assert property (reg_wr && reg_addr == 12'h45c ##1 !reg_wr ##1 rd_p |=> reg_rdata[7])
        else $error("mailbox event lost");
    cover property (rd_x);
    cover property (rd_e ##1 reg_rdata[20]);
    cover property (rd_p ##1 reg_rdata[ISC_P_GEN_LO]);
endmodule

bind isc_top isc_top_asserts isc_top_asserts_i (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .host_queue_pending(host_queue_pending), .dma_channel_event(dma_channel_event),
    .general_line_b(general_line_b), .cpu_bus_addr_parity_err(cpu_bus_addr_parity_err));

// [testbench/isc_top_tb_top.sv]
// Testbench: register view of the interrupt status collector
module isc_top_tb_top
    import isc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] single_rdata;
    logic [31:0] pv = 32'h0;
    logic [31:0] ev = 32'h0;
    logic [7:0]  pin_req = 8'h0;
    logic        first_pci_inta_b;
    logic        second_pci_inta_b;
    logic [5:0]  general_line_b;
    logic        irq_out;
    int          miscompares = 0;
    int          compares = 0;

    always #10 core_clk = ~core_clk;

    isc_top isc_top_i (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_queue_pending(pv[29]),
        .local_queue_pending(pv[28]), .dma_channel_event(pv[27:24]), .first_pci_inta_b(first_pci_inta_b),
        .second_pci_inta_b(second_pci_inta_b), .general_line_b(general_line_b), .cpu_retry_limit(ev[27:25]),
        .cpu_bus_transfer_error_ack(ev[23:21]), .cpu_bus_addr_parity_err(ev[20]), .cpu_data_parity_err(ev[19:17]),
        .second_pci_err(ev[15:13]), .second_pci_addr_parity_err(ev[12]), .second_pci_retry(ev[11:9]),
        .first_pci_err(ev[7:5]), .first_pci_addr_parity_err(ev[4]), .first_pci_retry(ev[3:1]), .irq_out(irq_out));
    isc_top #(.SINGLE_PCI(1'b1)) isc_top_single_i (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(single_rdata),
        .host_queue_pending(pv[29]), .local_queue_pending(pv[28]), .dma_channel_event(pv[27:24]),
        .first_pci_inta_b(first_pci_inta_b), .second_pci_inta_b(second_pci_inta_b), .general_line_b(general_line_b),
        .cpu_retry_limit(ev[27:25]), .cpu_bus_transfer_error_ack(ev[23:21]), .cpu_bus_addr_parity_err(ev[20]),
        .cpu_data_parity_err(ev[19:17]), .second_pci_err(ev[15:13]), .second_pci_addr_parity_err(ev[12]),
        .second_pci_retry(ev[11:9]), .first_pci_err(ev[7:5]), .first_pci_addr_parity_err(ev[4]),
        .first_pci_retry(ev[3:1]), .irq_out());
    isc_pin_model isc_pin_model_i (.core_clk(core_clk), .pin_req(pin_req), .first_pci_inta_b(first_pci_inta_b),
        .second_pci_inta_b(second_pci_inta_b), .general_line_b(general_line_b));

    task automatic give_verdict();
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask
    task automatic pulse(input logic [31:0] p, input logic [31:0] e);
        @(posedge core_clk);
        pv <= p;
        ev <= e;
        @(posedge core_clk);
        pv <= 32'h0;
        ev <= 32'h0;
    endtask

    // --------
    // Scenarios
    // --------
    task automatic s_dma();
        for (int i = 0; i < 5; i++) begin
            pulse(32'h1 << (24 + i), 32'h0);
            wr(ISC_PRIMARY_STATUS_OFS, 32'h0);
            rd(ISC_PRIMARY_STATUS_OFS, 32'h1 << (24 + i), "primary event");
            rd(ISC_ERROR_STATUS_OFS, 32'h80000000, "error summary");
            wr(ISC_PRIMARY_STATUS_OFS, 32'he0000000 | (32'h1 << (24 + i)));
            rd(ISC_PRIMARY_STATUS_OFS, 32'h0, "primary cleared");
        end
    endtask
    task automatic s_host();
        @(posedge core_clk);
        pv <= 32'h20000000;
        repeat (2) @(posedge core_clk);
        wr(ISC_PRIMARY_STATUS_OFS, 32'h20000000);
        rd(ISC_PRIMARY_STATUS_OFS, 32'h20000000, "host queue");
        chk("irq host", 32'h1, {31'h0, irq_out});
        wr(ISC_ENABLE_OFS, 32'h20000000);
        rd(ISC_ENABLE_OFS, 32'h20000000, "host mask");
        chk("irq host masked", 32'h0, {31'h0, irq_out});
        @(posedge core_clk);
        pv <= 32'h0;
        repeat (3) @(posedge core_clk);
        rd(ISC_PRIMARY_STATUS_OFS, 32'h0, "host queue idle");
    endtask
    task automatic s_pins();
        @(posedge core_clk);
        pin_req <= 8'hff;
        repeat (4) @(posedge core_clk);
        wr(ISC_PRIMARY_STATUS_OFS, 32'h00ff0000);
        rd(ISC_PRIMARY_STATUS_OFS, 32'h00ff0000, "line events");
        chk("single-PCI lines", 32'h007f0000, single_rdata);
        wr(ISC_ENABLE_OFS, 32'h00010000);
        repeat (2) @(posedge core_clk);
        #1 chk("irq enabled", 32'h1, {31'h0, irq_out});
        wr(ISC_ENABLE_OFS, 32'h0);
        repeat (2) @(posedge core_clk);
        #1 chk("irq masked", 32'h0, {31'h0, irq_out});
        @(posedge core_clk);
        pin_req <= 8'h0;
        repeat (5) @(posedge core_clk);
        wr(ISC_PRIMARY_STATUS_OFS, 32'h00ff0000);
        rd(ISC_PRIMARY_STATUS_OFS, 32'h0, "lines cleared");
    endtask
    task automatic s_bell();
        wr(ISC_ENABLE_OFS, 32'h0000ff00);
        for (int i = 0; i < 8; i++)
            wr(ISC_MAILBOX_BASE_OFS + 12'(4 * i), 32'h0);
        rd(ISC_PRIMARY_STATUS_OFS, 32'h0000ffff, "bells and mailboxes");
        wr(ISC_PRIMARY_STATUS_OFS, 32'h0000ffff);
        rd(ISC_PRIMARY_STATUS_OFS, 32'h0, "bells cleared");
    endtask
    task automatic s_err();
        pulse(32'h0, 32'h0efefefe);
        rd(ISC_ERROR_STATUS_OFS, 32'h0efefefe, "error events");
        chk("single-PCI errors", 32'h0aba0076, single_rdata);
        rd(ISC_PRIMARY_STATUS_OFS, 32'h80000000, "primary summary");
        chk("irq error masked", 32'h0, {31'h0, irq_out});
        wr(ISC_ERROR_ENABLE_OFS, 32'h00100000);
        rd(ISC_ERROR_ENABLE_OFS, 32'h00100000, "error enable");
        chk("irq error", 32'h1, {31'h0, irq_out});
        wr(ISC_ERROR_STATUS_OFS, 32'hffffffff);
        rd(ISC_ERROR_STATUS_OFS, 32'h0, "errors cleared");
        rd(ISC_PRIMARY_STATUS_OFS, 32'h0, "summary cleared");
    endtask
    task automatic s_reset();
        pulse(32'h01000000, 32'h00100000);
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(ISC_PRIMARY_STATUS_OFS, 32'h0, "primary after reset");
        rd(ISC_ERROR_STATUS_OFS, 32'h0, "error after reset");
        rd(ISC_ERROR_ENABLE_OFS, 32'h0, "error enable after reset");
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(ISC_PRIMARY_STATUS_OFS, 32'h0, "primary reset");
        rd(ISC_ERROR_STATUS_OFS, 32'h0, "error reset");
        rd(12'h400, 32'h0, "unmapped");
        s_dma();
        s_host();
        s_pins();
        s_bell();
        s_err();
        s_reset();
        give_verdict();
    end
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end
endmodule
